// >>> sim/core_model.sv
// ---------------------------------------------------------------------------
// core side model: issues checked accesses on consecutive edges
// ---------------------------------------------------------------------------
module core_model
(
   input  wire logic          clk_i,       // system clock
   input  wire logic          acc_done_i,  // result valid
   input  wire logic          acc_grant_i, // access allowed
   input  wire logic          acc_fault_i, // permission fault
   output logic               acc_valid_o, // request strobe
   output logic [31:0]        acc_addr_o,  // access address
   output mpu_pkg::acc_kind_e acc_kind_o,  // read, write or fetch
   output logic               acc_priv_o   // 1 privileged, 0 user
);
   timeunit 1ns;
   timeprecision 1ps;

   // idle values at time zero
   initial
   begin
      acc_valid_o = 1'b0;
      acc_addr_o  = 32'h0000_0000;
      acc_kind_o  = mpu_pkg::KIND_READ;
      acc_priv_o  = 1'b0;
   end

   // n requests back to back; result of request i read just after edge i+1
   task automatic burst(input int n, input logic [31:0] a[8], input mpu_pkg::acc_kind_e k[8],
                        input logic p[8], output logic [2:0] r[8]);
      for (int i = 0; i <= n; i++)
      begin
         @(posedge clk_i);
         if (i < n)
         begin
            acc_valid_o <= 1'b1;
            acc_addr_o  <= a[i];
            acc_kind_o  <= k[i];
            acc_priv_o  <= p[i];
         end
         else
         begin
            // released lines must not keep the last value
            acc_valid_o <= 1'b0;
            acc_addr_o  <= ~acc_addr_o;
            acc_kind_o  <= mpu_pkg::acc_kind_e'(~acc_kind_o);
            acc_priv_o  <= ~acc_priv_o;
         end
         if (i > 0)
         begin
            #1;
            r[i-1] = {acc_done_i, acc_grant_i, acc_fault_i};
         end
      end
   endtask
endmodule // core_model

// >>> sim/testbench.sv
`include "mpu_regs.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------------------------------------
   // signals and bench state
   // ------------------------------------------------------------------------
   logic               clk_sys, resetn, acc_valid, acc_priv, acc_done, acc_grant, acc_fault;
   logic [31:0]        acc_addr, avs_writedata, avs_readdata, rd;
   mpu_pkg::acc_kind_e acc_kind;
   logic [11:0]        avs_address;
   logic               avs_read, avs_write, avs_priv, avs_waitrequest, irq;
   logic [3:0]         avs_byteenable;
   int                 bad_count, n_compared, cycles;
   logic [31:0]        cfg_base[8], cfg_lim[8], qa[8];  // bench copy of regions
   logic [5:0]         cfg_attr[8];
   mpu_pkg::acc_kind_e qk[8];                           // pending burst
   logic               qp[8];
   logic [2:0]         qr[8];
   logic [3:0]         tbl[6] = '{4'h0, 4'h8, 4'h9, 4'ha, 4'h4, 4'h5}; // {priv,user}

   region_memory_access_checker dut_u (.clk_sys_i(clk_sys), .resetn_i(resetn),
      .acc_valid_i(acc_valid), .acc_addr_i(acc_addr), .acc_kind_i(acc_kind),
      .acc_priv_i(acc_priv), .acc_done_o(acc_done), .acc_grant_o(acc_grant),
      .acc_fault_o(acc_fault), .avs_address_i(avs_address), .avs_read_i(avs_read),
      .avs_write_i(avs_write), .avs_writedata_i(avs_writedata),
      .avs_byteenable_i(avs_byteenable), .avs_priv_i(avs_priv),
      .avs_readdata_o(avs_readdata), .avs_waitrequest_o(avs_waitrequest), .irq_o(irq));
   core_model core_u (.clk_i(clk_sys), .acc_done_i(acc_done), .acc_grant_i(acc_grant),
      .acc_fault_i(acc_fault), .acc_valid_o(acc_valid), .acc_addr_o(acc_addr),
      .acc_kind_o(acc_kind), .acc_priv_o(acc_priv));

   // ------------------------------------------------------------------------
   // clock, timeout and helpers
   // ------------------------------------------------------------------------
   initial
   begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   // a hang counts as a mismatch
   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         bad_count++;
         end_of_test();
      end
   end

   task automatic end_of_test();
      if (bad_count == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp)
      begin
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
         bad_count++;
      end
   endtask

   // expected {done,grant,fault}; later regions override earlier ones
   function automatic logic [2:0] exp_res(logic [31:0] a, mpu_pkg::acc_kind_e k, logic p);
      logic       hit;
      logic [5:0] at;
      logic [1:0] pm;
      logic       ok;
      hit = 1'b0;
      at  = 6'h00;
      for (int r = 0; r < 8; r++)
         if (cfg_attr[r][0] && a >= cfg_base[r] && a <= cfg_lim[r])
         begin
            hit = 1'b1;
            at  = cfg_attr[r];
         end
      pm = p ? at[2:1] : at[4:3];
      ok = (k == mpu_pkg::KIND_READ) ? (pm != 2'h0) :
           (k == mpu_pkg::KIND_WRITE) ? (pm == 2'h2) : (pm != 2'h0 && at[5]);
      if (!hit)
         ok = p;
      return {1'b1, ok, !ok};
   endfunction

   function automatic logic [11:0] reg_ofs(int r, logic [3:0] sub);
      return `MPU_OFS_REGION0 + `MPU_REGION_STRIDE * 12'(r) + {8'h00, sub};
   endfunction

   // one queued access for the core model
   task automatic fill(input int i, input logic [31:0] a, input int k, input logic p);
      qa[i] = a;
      qk[i] = mpu_pkg::acc_kind_e'(k);
      qp[i] = p;
   endtask

   // avalon-mm cycle: hold until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [11:0] ad, input logic [31:0] wd,
                      input logic pv, output logic [31:0] q);
      int t;
      @(posedge clk_sys);
      avs_address   <= ad;
      avs_read      <= !wr;
      avs_write     <= wr;
      avs_writedata <= wd;
      avs_priv      <= pv;
      t = 0;
      do
      begin
         @(posedge clk_sys);
         t++;
      end while (avs_waitrequest !== 1'b0 && t < 50);
      if (t >= 50)
      begin
         bad_count++;
         end_of_test();
      end
      q = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask

   task automatic cfg(input int r, input logic [31:0] b, input logic [31:0] l,
                      input logic [5:0] at);
      bus(1'b1, reg_ofs(r, `MPU_SUB_BASE), b, 1'b1, rd);
      bus(1'b1, reg_ofs(r, `MPU_SUB_LIMIT), l, 1'b1, rd);
      bus(1'b1, reg_ofs(r, `MPU_SUB_ATTR), {26'h0, at}, 1'b1, rd);
      cfg_base[r] = b;
      cfg_lim[r]  = l;
      cfg_attr[r] = at;
   endtask

   task automatic run(input int n, input string nm);
      core_u.burst(n, qa, qk, qp, qr);
      for (int i = 0; i < n; i++)
         chk(nm, 32'(exp_res(qa[i], qk[i], qp[i])), 32'(qr[i]));
   endtask

   task automatic irq_is(input logic v);
      repeat (3) @(posedge clk_sys);
      chk("irq", 32'(v), 32'(irq));
   endtask

   // ------------------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------------------
   initial
   begin
      {resetn, avs_read, avs_write, avs_priv, avs_address, avs_writedata} = '0;
      avs_byteenable = 4'hf;
      {bad_count, n_compared, cycles} = '0;
      for (int r = 0; r < 8; r++)
         {cfg_base[r], cfg_lim[r], cfg_attr[r]} = '0;
      void'($urandom(32'h048f));
      repeat (4) @(posedge clk_sys);
      resetn <= 1'b1;
      // defaults after reset, then background region
      for (int r = 0; r < 8; r++)
      begin
         bus(1'b0, reg_ofs(r, `MPU_SUB_ATTR), 32'h0, 1'b1, rd);
         chk("attr reset", 32'h0, rd);
      end
      for (int i = 0; i < 6; i++)
         fill(i, $urandom, i % 3, 1'(i / 3));
      run(6, "background");
      // all six listed permission pairs with fetch off and on
      for (int t = 0; t < 12; t++)
      begin
         cfg(0, 32'h0, 32'hffff_ffff, {1'(t), tbl[t/2][1:0], tbl[t/2][3:2], 1'b1});
         for (int i = 0; i < 6; i++)
            fill(i, $urandom, i % 3, 1'(i / 3));
         run(6, "perm table");
      end
      // overlapping random regions, back to back accesses, edges of windows
      repeat (10)
      begin
         for (int r = 0; r < 8; r++)
            cfg(r, 32'($urandom_range(255)), 32'($urandom_range(400)), 6'($urandom));
         repeat (4)
         begin
            for (int i = 0; i < 8; i++)
               fill(i, 32'($urandom_range(400)), int'($urandom_range(2)), 1'($urandom));
            qa[0] = cfg_base[$urandom_range(7)];
            qa[1] = cfg_lim[$urandom_range(7)];
            run(8, "overlap");
         end
      end
      // user master cannot touch configuration; unmapped reads zero
      bus(1'b1, reg_ofs(3, `MPU_SUB_ATTR), {26'h0, ~cfg_attr[3]}, 1'b0, rd);
      bus(1'b0, reg_ofs(3, `MPU_SUB_ATTR), 32'h0, 1'b1, rd);
      chk("attr after user write", {26'h0, cfg_attr[3]}, rd);
      bus(1'b0, reg_ofs(3, `MPU_SUB_ATTR), 32'h0, 1'b0, rd);
      chk("user read", 32'h0, rd);
      bus(1'b0, 12'hffc, 32'h0, 1'b1, rd);
      chk("unmapped", 32'h0, rd);
      // partial byte lanes on a base word
      avs_byteenable <= 4'h3;
      bus(1'b1, reg_ofs(3, `MPU_SUB_BASE), 32'hffff_ffff, 1'b1, rd);
      avs_byteenable <= 4'hf;
      bus(1'b0, reg_ofs(3, `MPU_SUB_BASE), 32'h0, 1'b1, rd);
      chk("base byte lanes", {cfg_base[3][31:16], 16'hffff}, rd);
      // interrupt: only write faults unmasked
      for (int r = 1; r < 8; r++)
         cfg(r, 32'h0, 32'h0, 6'h00);
      cfg(0, 32'h0, 32'hffff_ffff, 6'h0d);
      bus(1'b1, `MPU_OFS_MASK, 32'h2, 1'b1, rd);
      bus(1'b0, `MPU_OFS_STATUS, 32'h0, 1'b1, rd);
      fill(0, $urandom, int'(mpu_pkg::KIND_FETCH), 1'b0);
      run(1, "user fetch");
      irq_is(1'b0);
      fill(0, $urandom, int'(mpu_pkg::KIND_WRITE), 1'b0);
      run(1, "user write");
      irq_is(1'b1);
      bus(1'b0, `MPU_OFS_STATUS, 32'h0, 1'b1, rd);
      chk("status", 32'h6, rd);
      bus(1'b0, `MPU_OFS_FAULT_ADDR, 32'h0, 1'b1, rd);
      chk("fault addr", qa[0], rd);
      bus(1'b0, `MPU_OFS_FAULT_INFO, 32'h0, 1'b1, rd);
      chk("fault info", 32'h81, rd);
      irq_is(1'b0);
      // reset in mid run restores defaults
      resetn <= 1'b0;
      repeat (2) @(posedge clk_sys);
      resetn <= 1'b1;
      bus(1'b0, reg_ofs(0, `MPU_SUB_ATTR), 32'h0, 1'b1, rd);
      chk("attr second reset", 32'h0, rd);
      end_of_test();
   end
endmodule // testbench

// >>> src/mpu_pkg.sv
// ---------------------------------------------------------------------------
// shared types
// ---------------------------------------------------------------------------
package mpu_pkg;
   // kind of access presented by the core
   typedef enum logic [1:0] {KIND_READ, KIND_WRITE, KIND_FETCH} acc_kind_e;
   typedef logic [31:0] word_t;
endpackage

// >>> src/mpu_regs.svh
`ifndef MPU_REGS_SVH
`define MPU_REGS_SVH
// ---------------------------------------------------------------------------
// register map (byte addresses, one aligned word each)
// ---------------------------------------------------------------------------
`define MPU_OFS_STATUS     12'h000
`define MPU_OFS_MASK       12'h004
`define MPU_OFS_FAULT_ADDR 12'h008
`define MPU_OFS_FAULT_INFO 12'h00c
`define MPU_OFS_REGION0    12'h040
`define MPU_REGION_STRIDE  12'h010
`define MPU_SUB_BASE       4'h0
`define MPU_SUB_LIMIT      4'h4
`define MPU_SUB_ATTR       4'h8
// ---------------------------------------------------------------------------
// attribute field layout
// ---------------------------------------------------------------------------
`define MPU_ATTR_W         6
`define MPU_ATTR_EN        0
`define MPU_ATTR_PRIV_LO   1
`define MPU_ATTR_USER_LO   3
`define MPU_ATTR_FETCH     5
`define MPU_PERM_NONE      2'h0
`define MPU_PERM_RO        2'h1
`define MPU_PERM_RW        2'h2
// ---------------------------------------------------------------------------
// status bits and reset values
// ---------------------------------------------------------------------------
`define MPU_ST_W           3
`define MPU_ST_READ        0
`define MPU_ST_WRITE       1
`define MPU_ST_FETCH       2
`define MPU_RST_ATTR       6'h00
`define MPU_RST_BASE       32'h0000_0000
`define MPU_RST_LIMIT      32'h0000_0000
`define MPU_NUM_REGIONS    8
`endif

// >>> src/region_match.sv
`include "mpu_regs.svh"
// ---------------------------------------------------------------------------
// address compare and priority pick over all regions
// ---------------------------------------------------------------------------
module region_match
(
   input  wire logic [31:0]                    addr_i,   // access address
   input  wire logic [7:0][31:0]               base_i,   // inclusive low
   input  wire logic [7:0][31:0]               limit_i,  // inclusive high
   input  wire logic [7:0][`MPU_ATTR_W-1:0]    attr_i,   // per region attrs
   output logic                                hit_o,    // any region hit
   output logic [2:0]                          idx_o,    // winning region
   output logic [`MPU_ATTR_W-1:0]              attr_o    // winning attrs
);
   logic [7:0] match;   // per region hit vector

   // per region compare, only enabled regions take part
   genvar g;
   generate
      for (g = 0; g < `MPU_NUM_REGIONS; g++)
      begin : g_cmp
         assign match[g] = attr_i[g][`MPU_ATTR_EN] &&
                           (addr_i >= base_i[g]) && (addr_i <= limit_i[g]);
      end
   endgenerate

   always_comb
   begin
      hit_o  = 1'b0;
      idx_o  = 3'h0;
      attr_o = `MPU_RST_ATTR;
      for (int i = 0; i < `MPU_NUM_REGIONS; i++)
      begin
         // later, higher numbered hits overwrite lower ones
         if (match[i])
         begin
            hit_o  = 1'b1;
            idx_o  = 3'(i);
            attr_o = attr_i[i];
         end
      end
   end
endmodule // region_match

// >>> src/region_memory_access_checker.sv
// Local design decisions: the address map and the Avalon-MM register port.
`include "mpu_regs.svh"
// What this block does
// - checks depend on privileged or user level
// - eight regions plus privileged background region
// - overlapping regions: highest numbered region wins
// - privileged reaches user regions per privileged perm
// - user access to privileged-only region refused
// - per region fetch enable, forbidden fetch denied
// - none/none region blocks everything with fault
// - rw/none: privileged ok, user faults
// - rw/ro: user writes fault; rw/rw allows all
// - ro/none: privileged reads and enabled fetches only, rest faults
// - ro/ro: reads ok, all writes fault
// - reads, writes and fetches all checked
// - denied access never granted, result before completion
// - only privileged bus master touches config registers
// - attribute changes restricted to privileged software
// - reset loads fixed default attributes
module region_memory_access_checker
(
   input  wire logic              clk_sys_i,        // 25 MHz system clock
   input  wire logic              resetn_i,         // async reset, low
   // core access port
   input  wire logic              acc_valid_i,      // access request
   input  wire logic [31:0]       acc_addr_i,       // access address
   input  wire mpu_pkg::acc_kind_e acc_kind_i,      // read, write or fetch
   input  wire logic              acc_priv_i,       // 1 privileged, 0 user
   output logic                   acc_done_o,       // check result valid
   output logic                   acc_grant_o,      // access may proceed
   output logic                   acc_fault_o,      // permission fault
   // avalon-mm register slave
   input  wire logic [11:0]       avs_address_i,    // byte address
   input  wire logic              avs_read_i,       // read strobe
   input  wire logic              avs_write_i,      // write strobe
   input  wire logic [31:0]       avs_writedata_i,  // write data
   input  wire logic [3:0]        avs_byteenable_i, // byte lanes
   input  wire logic              avs_priv_i,       // master is privileged
   output logic [31:0]            avs_readdata_o,   // read data
   output logic                   avs_waitrequest_o,// stall
   output logic                   irq_o             // level interrupt
);
   // ------------------------------------------------------------------
   // storage
   // ------------------------------------------------------------------
   // eight region slots
   logic [7:0][31:0]             base_r;       // region low bounds
   logic [7:0][31:0]             limit_r;      // region high bounds
   logic [7:0][`MPU_ATTR_W-1:0]  attr_r;       // region attributes
   logic [`MPU_ST_W-1:0]         status_r;     // sticky fault bits
   logic [`MPU_ST_W-1:0]         status_nxt;   // next status
   logic [`MPU_ST_W-1:0]         mask_r;       // interrupt mask
   logic [31:0]                  fault_addr_r; // last faulting address
   logic [7:0]                   fault_info_r; // level, kind, region
   logic                         wait_r;       // waitrequest flop
   logic [31:0]                  rdata_r;      // read data flop
   logic                         done_r;       // result strobe
   logic                         grant_r;      // grant strobe
   logic                         fault_r;      // fault strobe
   logic                         irq_r;        // interrupt level

   // ------------------------------------------------------------------
   // region lookup
   // ------------------------------------------------------------------
   logic                         hit;          // any enabled region hit
   logic [2:0]                   hit_idx;      // winning region
   logic [`MPU_ATTR_W-1:0]       hit_attr;     // winning attributes
   logic [1:0]                   perm;         // perm for current level
   logic                         allow;        // combined decision

   region_match u_match
   (
      .addr_i  (acc_addr_i),
      .base_i  (base_r),
      .limit_i (limit_r),
      .attr_i  (attr_r),
      .hit_o   (hit),
      .idx_o   (hit_idx),
      .attr_o  (hit_attr)
   );

   // ------------------------------------------------------------------
   // permission decision
   // ------------------------------------------------------------------
   // select perm field by level
   assign perm = acc_priv_i ? hit_attr[`MPU_ATTR_PRIV_LO +: 2]
                            : hit_attr[`MPU_ATTR_USER_LO +: 2];

   // one table serves all six documented perm pairs
   always_comb
   begin
      allow = 1'b0;
      if (!hit)
      begin
         allow = acc_priv_i;
      end
      else
      begin
         case (acc_kind_i)
            mpu_pkg::KIND_READ:  allow = (perm != `MPU_PERM_NONE);
            mpu_pkg::KIND_WRITE: allow = (perm == `MPU_PERM_RW);
            mpu_pkg::KIND_FETCH: allow = (perm != `MPU_PERM_NONE) &&
                                         hit_attr[`MPU_ATTR_FETCH];
            default:             allow = 1'b0;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // access result strobes
   // ------------------------------------------------------------------
   // grant only when allowed, one cycle after request
   always_ff @(posedge clk_sys_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         done_r  <= 1'b0;
         grant_r <= 1'b0;
         fault_r <= 1'b0;
      end
      else
      begin
         done_r  <= acc_valid_i;
         grant_r <= acc_valid_i && allow;
         fault_r <= acc_valid_i && !allow;
      end
   end

   // fault capture for software diagnosis
   always_ff @(posedge clk_sys_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         fault_addr_r <= 32'h0000_0000;
         fault_info_r <= 8'h00;
      end
      else if (acc_valid_i && !allow)
      begin
         fault_addr_r <= acc_addr_i;
         fault_info_r <= {hit, hit_idx, acc_priv_i, 1'b0, acc_kind_i};
      end
   end

   // ------------------------------------------------------------------
   // avalon handshake: one wait cycle per access
   // ------------------------------------------------------------------
   logic bus_req;    // read or write pending
   logic bus_fire;   // access completes this edge
   logic bus_wr;     // privileged write completes
   logic bus_rd;     // read completes
   logic [3:0] sub;  // word within a region block
   logic [2:0] ridx; // region addressed
   logic [11:0] reg_rel; // offset into region area
   logic in_reg;     // address inside region area

   assign bus_req  = avs_read_i || avs_write_i;
   assign bus_fire = bus_req && !wait_r;
   assign bus_wr   = bus_fire && avs_write_i && avs_priv_i;
   assign bus_rd   = bus_fire && avs_read_i;
   assign sub      = avs_address_i[3:0];
   // slots count from the start of the region area, not from address
   // zero, so region 0 really is the lowest priority slot
   assign reg_rel  = avs_address_i - `MPU_OFS_REGION0;
   assign ridx     = reg_rel[6:4];
   assign in_reg   = (avs_address_i >= `MPU_OFS_REGION0) &&
                     (avs_address_i < 12'h0c0);

   // waitrequest drops for exactly one cycle per request
   always_ff @(posedge clk_sys_i or negedge resetn_i)
   begin
      if (!resetn_i)
         wait_r <= 1'b1;
      else
         wait_r <= !(bus_req && wait_r);
   end

   // read mux, loaded while waitrequest is still high
   always_ff @(posedge clk_sys_i or negedge resetn_i)
   begin
      if (!resetn_i)
         rdata_r <= 32'h0000_0000;
      else if (bus_req && wait_r)
      begin
         rdata_r <= 32'h0000_0000;
         if (!avs_priv_i || !avs_read_i)
            rdata_r <= 32'h0000_0000;
         else if (avs_address_i == `MPU_OFS_STATUS)
            // next value: a fault on the load edge would else be cleared unseen
            rdata_r <= {29'h0, status_nxt};
         else if (avs_address_i == `MPU_OFS_MASK)
            rdata_r <= {29'h0, mask_r};
         else if (avs_address_i == `MPU_OFS_FAULT_ADDR)
            rdata_r <= fault_addr_r;
         else if (avs_address_i == `MPU_OFS_FAULT_INFO)
            rdata_r <= {24'h0, fault_info_r};
         else if (in_reg && sub == `MPU_SUB_BASE)
            rdata_r <= base_r[ridx];
         else if (in_reg && sub == `MPU_SUB_LIMIT)
            rdata_r <= limit_r[ridx];
         else if (in_reg && sub == `MPU_SUB_ATTR)
            rdata_r <= {26'h0, attr_r[ridx]};
      end
   end

   // ------------------------------------------------------------------
   // region configuration writes
   // ------------------------------------------------------------------
   // only privileged writes change attributes
   always_ff @(posedge clk_sys_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         for (int i = 0; i < `MPU_NUM_REGIONS; i++)
         begin
            base_r[i]  <= `MPU_RST_BASE;
            limit_r[i] <= `MPU_RST_LIMIT;
            attr_r[i]  <= `MPU_RST_ATTR;
         end
      end
      else if (bus_wr && in_reg)
      begin
         // byte lanes honoured on the full words
         for (int b = 0; b < 4; b++)
         begin
            if (avs_byteenable_i[b] && sub == `MPU_SUB_BASE)
               base_r[ridx][8*b +: 8] <= avs_writedata_i[8*b +: 8];
            if (avs_byteenable_i[b] && sub == `MPU_SUB_LIMIT)
               limit_r[ridx][8*b +: 8] <= avs_writedata_i[8*b +: 8];
         end
         if (avs_byteenable_i[0] && sub == `MPU_SUB_ATTR)
            attr_r[ridx] <= avs_writedata_i[`MPU_ATTR_W-1:0];
      end
   end

   // ------------------------------------------------------------------
   // interrupt status, mask and line
   // ------------------------------------------------------------------
   always_comb
   begin
      status_nxt = status_r;
      // clear on privileged read of status
      if (bus_rd && avs_priv_i && avs_address_i == `MPU_OFS_STATUS)
         status_nxt = '0;
      // set wins over a clear in the same cycle
      if (acc_valid_i && !allow)
      begin
         case (acc_kind_i)
            mpu_pkg::KIND_READ:  status_nxt[`MPU_ST_READ]  = 1'b1;
            mpu_pkg::KIND_WRITE: status_nxt[`MPU_ST_WRITE] = 1'b1;
            default:             status_nxt[`MPU_ST_FETCH] = 1'b1;
         endcase
      end
   end

   // status flop
   always_ff @(posedge clk_sys_i or negedge resetn_i)
   begin
      if (!resetn_i)
         status_r <= '0;
      else
         status_r <= status_nxt;
   end

   // mask register, privileged writes only
   always_ff @(posedge clk_sys_i or negedge resetn_i)
   begin
      if (!resetn_i)
         mask_r <= '0;
      else if (bus_wr && avs_address_i == `MPU_OFS_MASK &&
               avs_byteenable_i[0])
         mask_r <= avs_writedata_i[`MPU_ST_W-1:0];
   end

   // interrupt trails status by one cycle
   always_ff @(posedge clk_sys_i or negedge resetn_i)
   begin
      if (!resetn_i)
         irq_r <= 1'b0;
      else
         irq_r <= |(status_r & mask_r);
   end

   assign acc_done_o        = done_r;
   assign acc_grant_o       = grant_r;
   assign acc_fault_o       = fault_r;
   assign avs_readdata_o    = rdata_r;
   assign avs_waitrequest_o = wait_r;
   assign irq_o             = irq_r;

   // ------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------
   AST_GRANT_XOR_FAULT: assert property (@(posedge clk_sys_i)
      disable iff (!resetn_i) acc_done_o |-> (acc_grant_o ^ acc_fault_o))
      else $error("grant and fault not exclusive");

   AST_BG_USER: assert property (@(posedge clk_sys_i)
      disable iff (!resetn_i)
      (acc_valid_i && !acc_priv_i && !hit) |=> acc_fault_o)
      else $error("user background access not faulted");

   AST_BG_PRIV: assert property (@(posedge clk_sys_i)
      disable iff (!resetn_i)
      (acc_valid_i && acc_priv_i && !hit) |=> acc_grant_o)
      else $error("privileged background access refused");

   AST_NO_PERM: assert property (@(posedge clk_sys_i)
      disable iff (!resetn_i)
      (acc_valid_i && hit && perm == `MPU_PERM_NONE) |=> acc_fault_o)
      else $error("access to no-access level granted");

   AST_RO_WRITE: assert property (@(posedge clk_sys_i)
      disable iff (!resetn_i)
      (acc_valid_i && hit && perm == `MPU_PERM_RO &&
       acc_kind_i == mpu_pkg::KIND_WRITE) |=> acc_fault_o)
      else $error("write to read-only region granted");

   AST_FETCH_OFF: assert property (@(posedge clk_sys_i)
      disable iff (!resetn_i)
      (acc_valid_i && hit && !hit_attr[`MPU_ATTR_FETCH] &&
       acc_kind_i == mpu_pkg::KIND_FETCH) |=> acc_fault_o)
      else $error("fetch from no-fetch region granted");

   AST_USER_CFG: assert property (@(posedge clk_sys_i)
      disable iff (!resetn_i)
      (bus_fire && avs_write_i && !avs_priv_i) |=> $stable(attr_r))
      else $error("user master changed attributes");

   AST_WAIT_ONE: assert property (@(posedge clk_sys_i)
      disable iff (!resetn_i)
      (bus_req && wait_r) |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
      else $error("waitrequest not one cycle low");

   AST_IRQ: assert property (@(posedge clk_sys_i)
      disable iff (!resetn_i)
      (acc_valid_i && !allow && mask_r[`MPU_ST_READ] &&
       acc_kind_i == mpu_pkg::KIND_READ) |-> ##2 irq_o)
      else $error("fault did not raise interrupt");
endmodule // region_memory_access_checker
